// *** brc_pkg.sv ***
package brc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] BRC_ADDR_BOOST_CTRL   = 4'h0;
  localparam logic [3:0] BRC_ADDR_CHARGER_CTRL = 4'h1;
  localparam logic [3:0] BRC_ADDR_STATUS       = 4'h2;

  localparam logic [7:0] BRC_BOOST_CTRL_RESET   = 8'h24;
  localparam logic [7:0] BRC_CHARGER_CTRL_RESET = 8'h00;

  localparam int BRC_STATE_LSB   = 0;
  localparam int BRC_STATE_MSB   = 2;
  localparam int BRC_CHARGER_DIRECTION_BIT_BIT    = 0;
  localparam int BRC_HOST_BIT    = 1;

  localparam logic [2:0] BRC_STATE_OFF = 3'h4;
  localparam logic [2:0] BRC_STATE_ON  = 3'h7;

  // status bit positions
  localparam int BRC_ST_FAULT  = 0;
  localparam int BRC_ST_BOOST  = 1;
  localparam int BRC_ST_ISO    = 2;
  localparam int BRC_ST_SSTART = 3;
  localparam int BRC_ST_SCLAT  = 4;
  localparam int BRC_ST_OVLAT  = 5;
  localparam int BRC_ST_UVEN   = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int BRC_CLK_MHZ       = 100;
  localparam int BRC_SOFT_START_US = 4000;
  localparam int BRC_SOFT_START_CYC = BRC_SOFT_START_US * BRC_CLK_MHZ;

  typedef enum logic [1:0] {
    BRC_OFF   = 2'b00,
    BRC_SOFT  = 2'b01,
    BRC_RUN   = 2'b10,
    BRC_TRIP  = 2'b11
  } brc_state_e;

endpackage

// *** brc_fault_if.sv ***
`timescale 1ns/1ps
interface brc_fault_if;
  logic uv;
  logic oc;
  logic sc;
  logic ov;
  logic sc_mask;
  logic sc_hit;
  logic ov_hit;
  logic soft_hold;
  logic active;

  modport src (output uv, output oc, output sc, output ov, input sc_mask,
               output sc_hit, output ov_hit, output soft_hold, input active);
  modport ctl (input uv, input oc, input sc, input ov, output sc_mask,
               input sc_hit, input ov_hit, input soft_hold, output active);
endinterface // brc_fault_if

// *** brc_soft_timer.sv ***
`timescale 1ns/1ps
module brc_soft_timer #(
  parameter int CYCLES = brc_pkg::BRC_SOFT_START_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic start_in,
  input  wire logic abort_in,
  output logic      busy_out
);
  import brc_pkg::*;

  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= '0;
    end else if (abort_in) begin
      count_reg <= '0;
    end else if (start_in) begin
      count_reg <= W'(CYCLES);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - W'(1);
    end
  end

  assign busy_out = (count_reg != '0);
endmodule // brc_soft_timer

// *** brc_fault_sense.sv ***
// How it works
// [R1] charger bit low: switch off, field drives boost
// [R2] charger high, host low: boost, switch on
// [R3] both high: switch off, field drives boost
// [R4] state field bits 2:0, reset 0x24
// [R5] turn-on sets flag until soft start ends
// [R6] under-voltage sets flag while it lasts
// [R7] over-current gates switch, sets flag
// [R8] short trips boost and switch, sets flag
// [R9] short latch cleared only by re-enable
// [R10] short ignored during soft start
// [R11] over-voltage trips boost, sets flag
// [R12] over-voltage cleared by off then on
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module brc_fault_sense (
  input  wire logic  clk_in,
  input  wire logic  reset_n_in,
  input  wire logic  uv_in,
  input  wire logic  oc_in,
  input  wire logic  sc_in,
  input  wire logic  ov_in,
  brc_fault_if.src   flt
);
  import brc_pkg::*;

  // comparator outputs are taken as synchronous; one stage aligns them
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flt.uv <= 1'b0;
      flt.oc <= 1'b0;
      flt.sc <= 1'b0;
      flt.ov <= 1'b0;
    end else begin
      flt.uv <= uv_in;
      flt.oc <= oc_in;
      flt.sc <= sc_in;
      flt.ov <= ov_in;
    end
  end

  // short ignored while soft start masks it
  assign flt.sc_hit    = flt.sc && !flt.sc_mask && flt.active;
  assign flt.ov_hit    = flt.ov && flt.active;
  // over-current holds the gate off while it lasts
  assign flt.soft_hold = flt.oc && flt.active;
endmodule // brc_fault_sense

// ----------------------------------------------------------------
// top: rail enable, isolation switch and fault flag
// ----------------------------------------------------------------
module boost_rail_enable_fault_ctrl #(
  parameter int SOFT_CYCLES = brc_pkg::BRC_SOFT_START_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       uv_in,
  input  wire logic       oc_in,
  input  wire logic       sc_in,
  input  wire logic       ov_in,
  output logic            boost_en_out,
  output logic            iso_en_out,
  output logic            fault_out,
  output logic            gate_off_out,
  output logic            uv_en_out
);
  import brc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  brc_fault_if u_flt ();

  logic [7:0] boost_ctrl_reg;
  logic [7:0] charger_ctrl_reg;
  logic       sc_lat_reg;
  logic       ov_lat_reg;
  logic       ov_off_seen_reg;
  brc_state_e state_reg;
  brc_state_e state_next;
  logic       boost_en_reg;
  logic       iso_en_reg;
  logic       fault_reg;
  logic       fault_next;
  logic       gate_off_reg;
  logic       uv_en_reg;
  logic [7:0] rdata_reg;
  logic [7:0] status_word;

  logic [2:0] state_field;
  logic       charger_direction_bit_bit;
  logic       host_bit;
  logic       field_on;
  logic       boost_req;
  logic       iso_req;
  logic       latched;
  logic       allow;
  logic       wr_boost;
  logic       wr_charger_direction_bit;
  logic       wr_on;
  logic       wr_off;
  logic       sc_hit;
  logic       ov_hit;
  logic       oc_hold;
  logic       run_next;
  logic       timer_start;
  logic       timer_abort;
  logic       timer_busy;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  brc_fault_sense u_sense (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .uv_in      (uv_in),
    .oc_in      (oc_in),
    .sc_in      (sc_in),
    .ov_in      (ov_in),
    .flt        (u_flt)
  );

  // [R10] soft start length
  brc_soft_timer #(
    .CYCLES (SOFT_CYCLES)
  ) u_soft (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .start_in   (timer_start),
    .abort_in   (timer_abort),
    .busy_out   (timer_busy)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign state_field = boost_ctrl_reg[BRC_STATE_MSB:BRC_STATE_LSB];
  assign charger_direction_bit_bit    = charger_ctrl_reg[BRC_CHARGER_DIRECTION_BIT_BIT];
  assign host_bit    = charger_ctrl_reg[BRC_HOST_BIT];
  // reserved and unused codes count as off
  assign field_on    = (state_field == BRC_STATE_ON);
  assign wr_boost    = reg_write_in && (reg_addr_in == BRC_ADDR_BOOST_CTRL);
  assign wr_charger_direction_bit     = reg_write_in && (reg_addr_in == BRC_ADDR_CHARGER_CTRL);
  assign wr_on       = wr_boost && (reg_wdata_in[BRC_STATE_MSB:BRC_STATE_LSB] == BRC_STATE_ON);
  assign wr_off      = wr_boost && (reg_wdata_in[BRC_STATE_MSB:BRC_STATE_LSB] == BRC_STATE_OFF);

  always_comb begin
    boost_req = 1'b0;
    iso_req   = 1'b0;
    if (!charger_direction_bit_bit) begin
      // [R1] field alone drives boost
      boost_req = field_on;
      iso_req   = 1'b0;
    end else if (!host_bit) begin
      // [R2] host mode forces both on
      boost_req = 1'b1;
      iso_req   = 1'b1;
    end else begin
      // [R3] switch off, field drives
      boost_req = field_on;
      iso_req   = 1'b0;
    end
  end

  assign latched = sc_lat_reg || ov_lat_reg;
  assign allow   = boost_req && !latched;

  // [R10] short masked during soft start
  assign u_flt.sc_mask = (state_reg == BRC_SOFT);
  assign u_flt.active  = (state_reg == BRC_SOFT) || (state_reg == BRC_RUN);
  assign sc_hit        = u_flt.sc_hit;
  assign ov_hit        = u_flt.ov_hit;
  assign oc_hold       = u_flt.soft_hold;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // [R4] control register reset value
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boost_ctrl_reg <= BRC_BOOST_CTRL_RESET;
    end else if (wr_boost) begin
      boost_ctrl_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      charger_ctrl_reg <= BRC_CHARGER_CTRL_RESET;
    end else if (wr_charger_direction_bit) begin
      charger_ctrl_reg <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------
  // [R9] short held until re-enable; a new hit wins over the clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sc_lat_reg <= 1'b0;
    end else if (sc_hit) begin
      sc_lat_reg <= 1'b1;
    end else if (wr_on) begin
      sc_lat_reg <= 1'b0;
    end
  end

  // [R12] over-voltage needs off then on
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ov_lat_reg <= 1'b0;
    end else if (ov_hit) begin
      ov_lat_reg <= 1'b1;
    end else if (wr_on && ov_off_seen_reg) begin
      ov_lat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ov_off_seen_reg <= 1'b0;
    end else if (ov_hit || !ov_lat_reg) begin
      ov_off_seen_reg <= 1'b0;
    end else if (wr_off) begin
      ov_off_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // rail state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BRC_OFF: begin
        if (allow) begin
          state_next = BRC_SOFT;
        end
      end
      BRC_SOFT: begin
        // [R11] over-voltage trips even in soft start
        if (sc_hit || ov_hit) begin
          state_next = BRC_TRIP;
        end else if (!allow) begin
          state_next = BRC_OFF;
        end else if (!timer_busy) begin
          state_next = BRC_RUN;
        end
      end
      BRC_RUN: begin
        // [R8] short or surge shuts down
        if (sc_hit || ov_hit) begin
          state_next = BRC_TRIP;
        end else if (!allow) begin
          state_next = BRC_OFF;
        end
      end
      BRC_TRIP: begin
        // no automatic restart: leaves only once software clears the latch
        if (!latched) begin
          state_next = BRC_OFF;
        end
      end
      default: begin
        state_next = BRC_OFF;
      end
    endcase
  end

  assign timer_start = (state_reg == BRC_OFF) && (state_next == BRC_SOFT);
  assign timer_abort = (state_reg == BRC_SOFT) && (state_next != BRC_SOFT);
  assign run_next    = (state_next == BRC_SOFT) || (state_next == BRC_RUN);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= BRC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // [R5] flag high through soft start and trips
  always_comb begin
    fault_next = 1'b0;
    if ((state_next == BRC_SOFT) || (state_next == BRC_TRIP)) begin
      fault_next = 1'b1;
    end else if (state_next == BRC_RUN) begin
      // [R6] under-voltage or [R7] over-current
      fault_next = u_flt.uv || oc_hold;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // [R8] switch follows the rail off on a trip
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boost_en_reg <= 1'b0;
      iso_en_reg   <= 1'b0;
    end else begin
      boost_en_reg <= run_next;
      iso_en_reg   <= run_next && iso_req;
    end
  end

  // [R6] comparator enabled while the rail runs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      uv_en_reg <= 1'b0;
    end else begin
      uv_en_reg <= run_next;
    end
  end

  // [R7] cycle limit: gate held off while current is high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_off_reg <= 1'b0;
    end else begin
      gate_off_reg <= run_next && oc_hold;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    status_word                = 8'h00;
    status_word[BRC_ST_FAULT]  = fault_reg;
    status_word[BRC_ST_BOOST]  = boost_en_reg;
    status_word[BRC_ST_ISO]    = iso_en_reg;
    status_word[BRC_ST_SSTART] = (state_reg == BRC_SOFT);
    status_word[BRC_ST_SCLAT]  = sc_lat_reg;
    status_word[BRC_ST_OVLAT]  = ov_lat_reg;
    status_word[BRC_ST_UVEN]   = uv_en_reg;
  end

  // data stands one cycle only, zero otherwise
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        BRC_ADDR_BOOST_CTRL: begin
          rdata_reg <= boost_ctrl_reg;
        end
        BRC_ADDR_CHARGER_CTRL: begin
          rdata_reg <= charger_ctrl_reg;
        end
        BRC_ADDR_STATUS: begin
          rdata_reg <= status_word;
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign boost_en_out  = boost_en_reg;
  assign iso_en_out    = iso_en_reg;
  assign fault_out     = fault_reg;
  assign gate_off_out  = gate_off_reg;
  assign uv_en_out     = uv_en_reg;
endmodule // boost_rail_enable_fault_ctrl

// *** brc_timer_chk.sv ***
`timescale 1ns/1ps
module brc_timer_chk (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       oc_in,
  input wire logic       sc_in,
  input wire logic       ov_in,
  input wire logic       boost_en_out,
  input wire logic       iso_en_out,
  input wire logic       fault_out,
  input wire logic       gate_off_out,
  input wire logic       uv_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_iso_with_boost: assert property (iso_en_out |-> boost_en_out)
    else $error("switch on without boost");
  a_turn_on_fault: assert property ($rose(boost_en_out) |-> fault_out)
    else $error("flag not set at turn-on");
  a_uv_enabled: assert property (boost_en_out |-> uv_en_out)
    else $error("under-voltage comparator off");
  a_short_trips: assert property (sc_in && boost_en_out && !fault_out |-> ##[1:3] !boost_en_out)
    else $error("short did not trip");
  a_surge_trips: assert property (ov_in && boost_en_out |-> ##[1:3] (!boost_en_out && fault_out))
    else $error("over-voltage did not trip");
  a_oc_gates: assert property (oc_in && boost_en_out |-> ##[1:3] (gate_off_out || !boost_en_out))
    else $error("over-current not gated");
  a_trip_holds: assert property (fault_out && !boost_en_out && !reg_write_in && !$past(reg_write_in)
                                 |=> fault_out)
    else $error("trip flag cleared itself");
  a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
endmodule // brc_timer_chk

// *** boost_rail_enable_fault_ctrl_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t compare failed", $time); end end

// ----------------------------------------------------------------
// partner: the rail and its comparators
// ----------------------------------------------------------------
module brc_rail_model #(
  parameter int RAMP = 4
) (
  input  wire logic clk_in,
  input  wire logic boost_en_in,
  input  wire logic sag_in,
  input  wire logic overload_in,
  input  wire logic short_in,
  input  wire logic surge_in,
  output logic      uv_out,
  output logic      oc_out,
  output logic      sc_out,
  output logic      ov_out
);
  int ramp_cnt = 0;
  // rail reads under-voltage while off and while ramping
  always @(posedge clk_in) begin
    if (!boost_en_in) begin
      ramp_cnt <= 0;
    end else if (ramp_cnt < RAMP) begin
      ramp_cnt <= ramp_cnt + 1;
    end
    uv_out <= !boost_en_in || (ramp_cnt < RAMP) || sag_in;
    oc_out <= overload_in;
    sc_out <= short_in;
    ov_out <= surge_in;
  end
endmodule // brc_rail_model

module boost_rail_enable_fault_ctrl_bench;
  import brc_pkg::*;
  localparam int SOFT  = 20;
  localparam int LIMIT = 200;
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_write_in = 1'b0;
  logic       reg_read_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       uv_in, oc_in, sc_in, ov_in;
  logic       boost_en_out, iso_en_out, fault_out, gate_off_out, uv_en_out;
  logic       sag = 1'b0, overload = 1'b0, short_req = 1'b0, surge = 1'b0;
  int         bad_count = 0;
  int         comparisons = 0;
  always #5 clk_in = ~clk_in;
  boost_rail_enable_fault_ctrl #(
    .SOFT_CYCLES (SOFT)
  ) dut (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_write_in  (reg_write_in),
    .reg_read_in   (reg_read_in),
    .reg_rdata_out (reg_rdata_out),
    .uv_in         (uv_in),
    .oc_in         (oc_in),
    .sc_in         (sc_in),
    .ov_in         (ov_in),
    .boost_en_out  (boost_en_out),
    .iso_en_out    (iso_en_out),
    .fault_out     (fault_out),
    .gate_off_out  (gate_off_out),
    .uv_en_out     (uv_en_out)
  );
  brc_rail_model #(
    .RAMP (4)
  ) u_rail (
    .clk_in      (clk_in),
    .boost_en_in (boost_en_out),
    .sag_in      (sag),
    .overload_in (overload),
    .short_in    (short_req),
    .surge_in    (surge),
    .uv_out      (uv_in),
    .oc_out      (oc_in),
    .sc_out      (sc_in),
    .ov_out      (ov_in)
  );
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] field_word(input logic [2:0] f);
    return {BRC_BOOST_CTRL_RESET[7:3], f};
  endfunction
  function automatic logic [7:0] charger_word(input logic charger_direction_bit, input logic host);
    logic [7:0] w;
    w = 8'h00;
    w[BRC_CHARGER_DIRECTION_BIT_BIT] = charger_direction_bit;
    w[BRC_HOST_BIT] = host;
    return w;
  endfunction
  // one idle edge after each write keeps the strobe from being set twice at one edge
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    reg_addr_in  <= addr;
    reg_wdata_in <= data;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    reg_addr_in <= addr;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(posedge clk_in);
    data = reg_rdata_out;
  endtask
  task automatic wait_boost(input logic want);
    int n;
    n = 0;
    while (boost_en_out !== want && n < LIMIT) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= LIMIT) begin
      bad_count++;
      $display("wrong value at %0t boost wait timed out", $time);
      report_and_stop();
    end
  endtask
  task automatic wait_fault(input logic want);
    int n;
    n = 0;
    while (fault_out !== want && n < LIMIT) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= LIMIT) begin
      bad_count++;
      $display("wrong value at %0t flag wait timed out", $time);
      report_and_stop();
    end
  endtask
  task automatic t_reset_values;
    logic [7:0] data;
    read_reg(BRC_ADDR_BOOST_CTRL, data);
    `CHK(data, BRC_BOOST_CTRL_RESET)
    read_reg(BRC_ADDR_CHARGER_CTRL, data);
    `CHK(data, BRC_CHARGER_CTRL_RESET)
    `CHK(boost_en_out, 1'b0)
    `CHK(iso_en_out, 1'b0)
    `CHK(fault_out, 1'b0)
    $display("test reset values done");
  endtask
  task automatic t_direct;
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_ON));
    wait_boost(1'b1);
    `CHK(fault_out, 1'b1)
    `CHK(uv_en_out, 1'b1)
    `CHK(iso_en_out, 1'b0)
    wait_fault(1'b0);
    write_reg(BRC_ADDR_CHARGER_CTRL, charger_word(1'b0, 1'b1));
    repeat (3) @(posedge clk_in);
    `CHK(iso_en_out, 1'b0)
    `CHK(boost_en_out, 1'b1)
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_OFF));
    wait_boost(1'b0);
    `CHK(fault_out, 1'b0)
    $display("test direct control done");
  endtask
  task automatic t_host;
    write_reg(BRC_ADDR_CHARGER_CTRL, charger_word(1'b1, 1'b0));
    wait_boost(1'b1);
    `CHK(iso_en_out, 1'b1)
    wait_fault(1'b0);
    write_reg(BRC_ADDR_CHARGER_CTRL, charger_word(1'b1, 1'b1));
    wait_boost(1'b0);
    `CHK(iso_en_out, 1'b0)
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_ON));
    wait_boost(1'b1);
    `CHK(iso_en_out, 1'b0)
    wait_fault(1'b0);
    $display("test host mode done");
  endtask
  task automatic t_uv_oc;
    sag <= 1'b1;
    wait_fault(1'b1);
    `CHK(boost_en_out, 1'b1)
    sag <= 1'b0;
    wait_fault(1'b0);
    `CHK(boost_en_out, 1'b1)
    overload <= 1'b1;
    wait_fault(1'b1);
    repeat (2) @(posedge clk_in);
    `CHK(gate_off_out, 1'b1)
    overload <= 1'b0;
    wait_fault(1'b0);
    `CHK(gate_off_out, 1'b0)
    $display("test under-voltage and over-current done");
  endtask
  task automatic t_short;
    write_reg(BRC_ADDR_CHARGER_CTRL, charger_word(1'b0, 1'b0));
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_OFF));
    wait_boost(1'b0);
    short_req <= 1'b1;
    write_reg(BRC_ADDR_CHARGER_CTRL, charger_word(1'b1, 1'b0));
    wait_boost(1'b1);
    `CHK(iso_en_out, 1'b1)
    repeat (SOFT / 2) @(posedge clk_in);
    `CHK(boost_en_out, 1'b1)
    wait_boost(1'b0);
    `CHK(fault_out, 1'b1)
    `CHK(iso_en_out, 1'b0)
    short_req <= 1'b0;
    repeat (30) @(posedge clk_in);
    `CHK(boost_en_out, 1'b0)
    `CHK(fault_out, 1'b1)
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_ON));
    wait_boost(1'b1);
    wait_fault(1'b0);
    $display("test short circuit done");
  endtask
  task automatic t_surge;
    surge <= 1'b1;
    wait_boost(1'b0);
    `CHK(fault_out, 1'b1)
    surge <= 1'b0;
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_ON));
    repeat (5) @(posedge clk_in);
    `CHK(boost_en_out, 1'b0)
    `CHK(fault_out, 1'b1)
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_OFF));
    write_reg(BRC_ADDR_BOOST_CTRL, field_word(BRC_STATE_ON));
    wait_boost(1'b1);
    wait_fault(1'b0);
    `CHK(fault_out, 1'b0)
    $display("test over-voltage done");
  endtask
  task automatic t_mid_reset;
    logic [7:0] data;
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK(boost_en_out, 1'b0)
    `CHK(fault_out, 1'b0)
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    read_reg(BRC_ADDR_BOOST_CTRL, data);
    `CHK(data, BRC_BOOST_CTRL_RESET)
    `CHK(boost_en_out, 1'b0)
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset_values();
    t_direct();
    t_host();
    t_uv_oc();
    t_short();
    t_surge();
    t_mid_reset();
    report_and_stop();
  end
endmodule // boost_rail_enable_fault_ctrl_bench

bind boost_rail_enable_fault_ctrl brc_timer_chk u_chk (
  .clk_in        (clk_in),
  .reset_n_in    (reset_n_in),
  .reg_write_in  (reg_write_in),
  .reg_read_in   (reg_read_in),
  .reg_rdata_out (reg_rdata_out),
  .oc_in         (oc_in),
  .sc_in         (sc_in),
  .ov_in         (ov_in),
  .boost_en_out  (boost_en_out),
  .iso_en_out    (iso_en_out),
  .fault_out     (fault_out),
  .gate_off_out  (gate_off_out),
  .uv_en_out     (uv_en_out)
);
